// >>> inc/timer16_pkg.sv
// constants shared by the 16-bit timer register block
// Operation
// [RQ1] filter enabled: capture input changes after four equal samples, adding four cycles
// [RQ2] edge select low triggers capture on falling edge, high on rising edge
// [RQ3] each capture event copies the counter to the capture value and sets flag; a capture low-byte write in the same cycle replaces the copy
// [RQ4] modes using the capture value as maximum disable the capture function
// [RQ5] clock select 000 stops; 001 to 101 divide clock by 1,8,64,256,1024
// [RQ6] clock select 110 and 111 count external pin falling and rising edges
// [RQ7] force compare bits act only in non-PWM wave modes
// [RQ8] force compare applies an immediate match to the channel output per output mode
// [RQ9] forced match sets no flag and never clears the counter
// [RQ10] force compare bits are strobes and always read as zero
// [RQ11] counter bytes are accessed atomically through the shared high-byte buffer
// [RQ12] a counter write blocks compare matches on the next timer tick
// [RQ13] capture source is the capture pin or, if selected, the analog comparator
// [RQ14] capture value can serve as counter maximum in the modes that select it
// [RQ15] compare A value is compared continuously; a match sets flag and drives output
// [RQ16] compare A writes update both bytes together via the high-byte buffer
// [RQ17] capture reads return a coherent byte pair via the high-byte buffer
// [RQ18] software should not change the counter while running or matches may be missed
// [RQ19] four-bit wave mode picks counting, maximum and update point; 4 is clear-on-match
// [RQ20] flags clear when serviced or when software writes one to them
// [RQ21] high byte written first, low write commits; low read latches high byte
package timer16_pkg;
    localparam logic [7:0] ADDR_CTRL_B = 8'h81;
    localparam logic [7:0] ADDR_CTRL_C = 8'h82;
    localparam logic [7:0] ADDR_CNT_L = 8'h84;
    localparam logic [7:0] ADDR_CNT_H = 8'h85;
    localparam logic [7:0] ADDR_CAP_L = 8'h86;
    localparam logic [7:0] ADDR_CAP_H = 8'h87;
    localparam logic [7:0] ADDR_CMPA_L = 8'h88;
    localparam logic [7:0] ADDR_CMPA_H = 8'h89;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0] CTRL_B_MASK = 8'hDF;
    localparam int CTRL_B_FILTER_BIT = 7;
    localparam int CTRL_B_EDGE_BIT = 6;
    localparam int CTRL_B_WAVE3_BIT = 4;
    localparam int CTRL_B_WAVE2_BIT = 3;
    localparam int CTRL_C_FORCE_A_BIT = 7;
    localparam int CTRL_C_FORCE_B_BIT = 6;
    localparam logic [2:0] CLK_STOP = 3'h0;
    localparam logic [2:0] CLK_DIV1 = 3'h1;
    localparam logic [2:0] CLK_DIV8 = 3'h2;
    localparam logic [2:0] CLK_DIV64 = 3'h3;
    localparam logic [2:0] CLK_DIV256 = 3'h4;
    localparam logic [2:0] CLK_DIV1024 = 3'h5;
    localparam logic [2:0] CLK_EXT_FALL = 3'h6;
    localparam logic [2:0] CLK_EXT_RISE = 3'h7;
    localparam int PRESC_W = 10;
    localparam logic [9:0] PRESC_RESET = 10'h000;
    localparam logic [9:0] PRESC_MASK8 = 10'h007;
    localparam logic [9:0] PRESC_MASK64 = 10'h03F;
    localparam logic [9:0] PRESC_MASK256 = 10'h0FF;
    localparam logic [9:0] PRESC_MASK1024 = 10'h3FF;
    localparam int FILTER_LEN = 4;
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
    localparam logic [15:0] TOP_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_CTC_CMP = 4'h4;
    localparam logic [3:0] MODE_PFC_CAP = 4'h8;
    localparam logic [3:0] MODE_PFC_CMP = 4'h9;
    localparam logic [3:0] MODE_CTC_CAP = 4'hC;
    localparam logic [3:0] MODE_RESERVED = 4'hD;
endpackage : timer16_pkg

// >>> rtl/timer16_capture_compare_regs.sv
// 16-bit timer/counter with capture, compare A and byte-wide register port
`timescale 1ns/1ps
module timer16_capture_compare_regs
    import timer16_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] busAddr,
    input wire logic busWrEn,
    input wire logic [7:0] busWrData,
    input wire logic busRdEn,
    output logic [7:0] busRdData,
    input wire logic [1:0] waveModeLow,
    input wire logic [1:0] compareOutputModeA,
    input wire logic [1:0] compareOutputModeB,
    input wire logic captureSourceAnalog,
    input wire logic analogCompOut,
    input wire logic captureInputPin,
    input wire logic externalCountPin,
    input wire logic captureFlagClr,
    input wire logic compareAFlagClr,
    input wire logic overflowFlagClr,
    output logic captureFlag,
    output logic compareAFlag,
    output logic overflowFlag,
    output logic waveOutA,
    output logic waveOutB
);

    typedef struct packed {
        logic [7:0] ctlB;
        logic [15:0] cnt;
        logic [15:0] ocrA;
        logic [15:0] ocrABuf;
        logic [15:0] icr;
        logic [7:0] temp;
        logic [PRESC_W-1:0] presc;
        logic extSamp;
        logic extPrev;
        logic [FILTER_LEN-1:0] capSamp;
        logic capFilt;
        logic capPrev;
        logic countDown;
        logic blockMatch;
        logic capFlag;
        logic cmpAFlag;
        logic ovfFlag;
        logic outA;
        logic outB;
        logic [7:0] rdData;
    } state_t;

    localparam state_t STATE_RESET = '{
        ctlB: REG_RESET, cnt: WORD_RESET, ocrA: WORD_RESET, ocrABuf: WORD_RESET,
        icr: WORD_RESET, temp: REG_RESET, presc: PRESC_RESET, extSamp: 1'b0,
        extPrev: 1'b0, capSamp: '0, capFilt: 1'b0, capPrev: 1'b0, countDown: 1'b0,
        blockMatch: 1'b0, capFlag: 1'b0, cmpAFlag: 1'b0, ovfFlag: 1'b0,
        outA: 1'b0, outB: 1'b0, rdData: REG_RESET};

    state_t st_r;
    state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // mode decode
    logic [3:0] waveMode;
    logic [2:0] clkSel;
    logic filterEn;
    logic edgeRise;
    logic isPhase;
    logic isFast;
    logic isPwm;
    logic capIsTop;
    logic cmpIsTop;
    logic [15:0] topValue;

    assign waveMode = {st_r.ctlB[CTRL_B_WAVE3_BIT], st_r.ctlB[CTRL_B_WAVE2_BIT], waveModeLow};
    assign clkSel = st_r.ctlB[2:0];
    assign filterEn = st_r.ctlB[CTRL_B_FILTER_BIT];
    assign edgeRise = st_r.ctlB[CTRL_B_EDGE_BIT];
    // reserved mode 13 behaves as plain normal counting
    assign isPhase = (waveMode inside {4'h1, 4'h2, 4'h3, MODE_PFC_CAP, MODE_PFC_CMP, 4'hA, 4'hB});
    assign isFast = (waveMode inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF});
    assign isPwm = isPhase || isFast; // RQ19
    assign capIsTop = (waveMode inside {MODE_PFC_CAP, 4'hA, MODE_CTC_CAP, 4'hE}); // RQ14
    assign cmpIsTop = (waveMode inside {MODE_CTC_CMP, MODE_PFC_CMP, 4'hB, 4'hF});

    always_comb begin
        unique case (waveMode[1:0])
            2'h1: topValue = TOP_8BIT;
            2'h2: topValue = TOP_9BIT;
            2'h3: topValue = TOP_10BIT;
            default: topValue = TOP_MAX;
        endcase
        if (waveMode == MODE_NORMAL || waveMode == MODE_RESERVED) begin
            topValue = TOP_MAX;
        end
        if (capIsTop) begin
            topValue = st_r.icr; // RQ14
        end
        if (cmpIsTop) begin
            topValue = st_r.ocrA; // RQ19
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timer clock enable
    logic tick;
    logic extRise;
    logic extFall;

    assign extRise = st_r.extSamp && !st_r.extPrev;
    assign extFall = !st_r.extSamp && st_r.extPrev;

    always_comb begin
        unique case (clkSel) // RQ5
            CLK_STOP: tick = 1'b0;
            CLK_DIV1: tick = 1'b1;
            CLK_DIV8: tick = (st_r.presc & PRESC_MASK8) == PRESC_MASK8;
            CLK_DIV64: tick = (st_r.presc & PRESC_MASK64) == PRESC_MASK64;
            CLK_DIV256: tick = (st_r.presc & PRESC_MASK256) == PRESC_MASK256;
            CLK_DIV1024: tick = (st_r.presc & PRESC_MASK1024) == PRESC_MASK1024;
            CLK_EXT_FALL: tick = extFall; // RQ6
            CLK_EXT_RISE: tick = extRise; // RQ6
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // capture path and compare events
    logic capSource;
    logic capAllSame;
    logic capEvent;
    logic atTop;
    logic atBottom;
    logic matchA;
    logic wrLowCnt;
    logic forceA;
    logic forceB;

    assign capSource = captureSourceAnalog ? analogCompOut : captureInputPin; // RQ13
    assign capAllSame = (st_r.capSamp == '0) || (st_r.capSamp == '1);
    assign capEvent = !capIsTop && (st_r.capFilt != st_r.capPrev)
        && (st_r.capFilt == edgeRise); // RQ2 RQ4
    assign atTop = st_r.cnt == topValue;
    assign atBottom = st_r.countDown && st_r.cnt == WORD_RESET;
    assign matchA = tick && !st_r.blockMatch && st_r.cnt == st_r.ocrA; // RQ12 RQ15
    assign wrLowCnt = busWrEn && busAddr == ADDR_CNT_L;
    assign forceA = busWrEn && busAddr == ADDR_CTRL_C && busWrData[CTRL_C_FORCE_A_BIT] && !isPwm;
    assign forceB = busWrEn && busAddr == ADDR_CTRL_C && busWrData[CTRL_C_FORCE_B_BIT] && !isPwm;

    function automatic logic nonPwmAction(input logic cur, input logic [1:0] com);
        logic res;
        unique case (com)
            COM_OFF: res = cur;
            COM_TOGGLE: res = ~cur;
            COM_CLEAR: res = 1'b0;
            COM_SET: res = 1'b1;
        endcase
        return res;
    endfunction : nonPwmAction

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.presc = st_r.presc + 1'b1;
        st_nxt.extSamp = externalCountPin;
        st_nxt.extPrev = st_r.extSamp;
        st_nxt.capSamp = {st_r.capSamp[FILTER_LEN-2:0], capSource};
        // filter holds its output until the whole sample window agrees
        if (filterEn) begin
            st_nxt.capFilt = capAllSame ? st_r.capSamp[0] : st_r.capFilt; // RQ1
        end else begin
            st_nxt.capFilt = capSource;
        end
        st_nxt.capPrev = st_r.capFilt;

        if (tick) begin
            st_nxt.blockMatch = 1'b0;
            if (isPhase) begin
                if (!st_r.countDown) begin
                    if (st_r.cnt >= topValue) begin
                        st_nxt.countDown = 1'b1;
                        st_nxt.cnt = st_r.cnt - 1'b1;
                    end else begin
                        st_nxt.cnt = st_r.cnt + 1'b1;
                    end
                end else if (st_r.cnt == WORD_RESET) begin
                    st_nxt.countDown = 1'b0;
                    st_nxt.cnt = st_r.cnt + 1'b1;
                end else begin
                    st_nxt.cnt = st_r.cnt - 1'b1;
                end
            end else begin
                st_nxt.countDown = 1'b0;
                st_nxt.cnt = atTop ? WORD_RESET : st_r.cnt + 1'b1;
            end
        end

        // pwm modes load compare A from its buffer at top or bottom
        if (tick && isPwm) begin
            if (isPhase && !(waveMode inside {MODE_PFC_CAP, MODE_PFC_CMP}) ? atTop
                : (isPhase ? atBottom : atTop)) begin
                st_nxt.ocrA = st_r.ocrABuf;
            end
        end

        if (matchA) begin
            if (!isPwm) begin
                st_nxt.outA = nonPwmAction(st_r.outA, compareOutputModeA); // RQ15
            end else if (compareOutputModeA == COM_TOGGLE) begin
                st_nxt.outA = cmpIsTop ? ~st_r.outA : st_r.outA;
            end else if (compareOutputModeA[1]) begin
                st_nxt.outA = (compareOutputModeA == COM_SET) ^ (isPhase && st_r.countDown);
            end
        end
        if (tick && isFast && atTop && compareOutputModeA[1]) begin
            st_nxt.outA = compareOutputModeA == COM_CLEAR;
        end
        if (forceA) begin
            st_nxt.outA = nonPwmAction(st_r.outA, compareOutputModeA); // RQ7 RQ8
        end
        if (forceB) begin
            st_nxt.outB = nonPwmAction(st_r.outB, compareOutputModeB); // RQ7 RQ8
        end

        if (capEvent) begin
            st_nxt.icr = st_r.cnt; // RQ3
        end

        // hardware set beats a clear arriving in the same cycle
        st_nxt.capFlag = (st_r.capFlag && !captureFlagClr) || capEvent
            || (capIsTop && tick && atTop); // RQ3 RQ20
        st_nxt.cmpAFlag = (st_r.cmpAFlag && !compareAFlagClr) || matchA; // RQ9 RQ20
        st_nxt.ovfFlag = (st_r.ovfFlag && !overflowFlagClr) || (tick && (isPhase ? atBottom
            : (isFast ? atTop : st_r.cnt == TOP_MAX))); // RQ20

        st_nxt.rdData = REG_RESET;
        if (busRdEn) begin
            unique case (busAddr)
                ADDR_CTRL_B: st_nxt.rdData = st_r.ctlB & CTRL_B_MASK;
                ADDR_CTRL_C: st_nxt.rdData = REG_RESET; // RQ10
                ADDR_CNT_L: begin
                    st_nxt.rdData = st_r.cnt[7:0];
                    st_nxt.temp = st_r.cnt[15:8]; // RQ11 RQ21
                end
                ADDR_CAP_L: begin
                    st_nxt.rdData = st_r.icr[7:0];
                    st_nxt.temp = st_r.icr[15:8]; // RQ17 RQ21
                end
                ADDR_CNT_H, ADDR_CAP_H: st_nxt.rdData = st_r.temp; // RQ17
                ADDR_CMPA_L: st_nxt.rdData = st_r.ocrABuf[7:0];
                ADDR_CMPA_H: st_nxt.rdData = st_r.ocrABuf[15:8];
                default: st_nxt.rdData = REG_RESET;
            endcase
        end

        if (busWrEn) begin
            unique case (busAddr)
                ADDR_CTRL_B: st_nxt.ctlB = busWrData & CTRL_B_MASK;
                ADDR_CNT_H, ADDR_CAP_H, ADDR_CMPA_H: st_nxt.temp = busWrData; // RQ21
                ADDR_CNT_L: begin
                    st_nxt.cnt = {st_r.temp, busWrData}; // RQ11
                    st_nxt.blockMatch = 1'b1; // RQ12
                end
                ADDR_CAP_L: st_nxt.icr = {st_r.temp, busWrData};
                ADDR_CMPA_L: begin
                    st_nxt.ocrABuf = {st_r.temp, busWrData}; // RQ16
                    if (!isPwm) begin
                        st_nxt.ocrA = {st_r.temp, busWrData}; // RQ16
                    end
                end
                default: st_nxt.temp = st_r.temp;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= STATE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busRdData = st_r.rdData;
    assign captureFlag = st_r.capFlag;
    assign compareAFlag = st_r.cmpAFlag;
    assign overflowFlag = st_r.ovfFlag;
    assign waveOutA = st_r.outA;
    assign waveOutB = st_r.outB;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_filterWindow;
        @(posedge clk) disable iff (rst)
        ($past(filterEn) && $changed(st_r.capFilt))
            |-> ($past(st_r.capSamp) == '0 || $past(st_r.capSamp) == '1);
    endproperty
    a_filterWindow: assert property (p_filterWindow) else $error("filter moved early"); // RQ1
    property p_edgeDir;
        @(posedge clk) disable iff (rst)
        capEvent |-> (st_r.capFilt == edgeRise && st_r.capPrev != edgeRise);
    endproperty
    a_edgeDir: assert property (p_edgeDir) else $error("capture on wrong edge"); // RQ2
    property p_captureLoad;
        @(posedge clk) disable iff (rst)
        (capEvent && !(busWrEn && busAddr == ADDR_CAP_L))
            |=> (st_r.icr == $past(st_r.cnt) && captureFlag);
    endproperty
    a_captureLoad: assert property (p_captureLoad) else $error("capture not loaded"); // RQ3
    property p_captureOff;
        @(posedge clk) disable iff (rst)
        (capIsTop && !(busWrEn && busAddr == ADDR_CAP_L)) |=> $stable(st_r.icr);
    endproperty
    a_captureOff: assert property (p_captureOff) else $error("capture active at top"); // RQ4
    property p_stopped;
        @(posedge clk) disable iff (rst)
        (clkSel == CLK_STOP && !wrLowCnt) |=> $stable(st_r.cnt);
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped counter moved"); // RQ5
    property p_extIdle;
        @(posedge clk) disable iff (rst)
        (clkSel == CLK_EXT_RISE && st_r.extSamp == st_r.extPrev) |-> !tick;
    endproperty
    a_extIdle: assert property (p_extIdle) else $error("tick without pin edge"); // RQ6
    property p_forcePwm;
        @(posedge clk) disable iff (rst)
        (isPwm && !tick && busWrEn && busAddr == ADDR_CTRL_C) |=> $stable(waveOutB);
    endproperty
    a_forcePwm: assert property (p_forcePwm) else $error("force acted in pwm"); // RQ7
    property p_forceNoFlag;
        @(posedge clk) disable iff (rst)
        $rose(compareAFlag) |-> $past(matchA);
    endproperty
    a_forceNoFlag: assert property (p_forceNoFlag) else $error("flag without match"); // RQ9
    property p_forceReadZero;
        @(posedge clk) disable iff (rst)
        (busRdEn && busAddr == ADDR_CTRL_C) |=> busRdData == REG_RESET;
    endproperty
    a_forceReadZero: assert property (p_forceReadZero) else $error("force bits read"); // RQ10
    property p_counterWrite;
        @(posedge clk) disable iff (rst)
        wrLowCnt |=> st_r.cnt == {$past(st_r.temp), $past(busWrData)} ##0 st_r.blockMatch;
    endproperty
    a_counterWrite: assert property (p_counterWrite) else $error("counter write lost"); // RQ11
    property p_blockMatch;
        @(posedge clk) disable iff (rst)
        (tick && st_r.blockMatch) |=> !$rose(compareAFlag);
    endproperty
    a_blockMatch: assert property (p_blockMatch) else $error("match not blocked"); // RQ12
    property p_captureRead;
        @(posedge clk) disable iff (rst)
        (busRdEn && busAddr == ADDR_CAP_L && !busWrEn) ##1 !(busWrEn || busRdEn)
            ##1 (busRdEn && busAddr == ADDR_CAP_H) |=> busRdData == $past(st_r.icr[15:8], 3);
    endproperty
    a_captureRead: assert property (p_captureRead) else $error("capture pair torn"); // RQ17
    property p_flagClear;
        @(posedge clk) disable iff (rst)
        (overflowFlagClr && !tick) |=> !overflowFlag;
    endproperty
    a_flagClear: assert property (p_flagClear) else $error("flag not cleared"); // RQ20
    c_capture: cover property (@(posedge clk) disable iff (rst) capEvent);
    c_matchA: cover property (@(posedge clk) disable iff (rst) matchA && !isPwm);
    c_forceA: cover property (@(posedge clk) disable iff (rst) forceA);
    c_phaseTurn: cover property (@(posedge clk) disable iff (rst) tick && atBottom);

endmodule : timer16_capture_compare_regs

// >>> verification/pin_side_model.sv
// pin-side partner: capture pin, comparator output and external count pin
`timescale 1ns/1ps
module pin_side_model (
    input wire logic clk,
    output logic capPin,
    output logic anaOut,
    output logic cntPin
);
    initial begin
        capPin = 1'b0;
        anaOut = 1'b0;
        cntPin = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // sel 0 capture pin, 1 comparator, 2 count pin; level changes at falling edge
    task automatic drive(input int sel, input logic lvl, input int n);
        @(negedge clk);
        if (sel == 0) capPin = lvl;
        else if (sel == 1) anaOut = lvl;
        else cntPin = lvl;
        repeat (n) @(negedge clk);
    endtask : drive
    // each level held several cycles so the pin synchroniser never misses an edge
    task automatic countPulses(input int n);
        repeat (n) begin
            drive(2, 1'b1, 3);
            drive(2, 1'b0, 3);
        end
    endtask : countPulses
endmodule : pin_side_model

// >>> verification/testbench.sv
// self-checking bench for the 16-bit timer register block
`timescale 1ns/1ps
module testbench;
    import timer16_pkg::*;
    logic clk, rst, busWrEn, busRdEn, captureSourceAnalog, analogCompOut;
    logic captureInputPin, externalCountPin, captureFlagClr, compareAFlagClr, overflowFlagClr;
    logic captureFlag, compareAFlag, overflowFlag, waveOutA, waveOutB;
    logic [7:0] busAddr, busWrData, busRdData;
    logic [1:0] waveModeLow, compareOutputModeA, compareOutputModeB;
    int n_mismatch = 0;
    int checked = 0;
    int divs[5] = '{1, 8, 64, 256, 1024};

    timer16_capture_compare_regs i_dut (.clk(clk), .rst(rst), .busAddr(busAddr),
        .busWrEn(busWrEn), .busWrData(busWrData), .busRdEn(busRdEn), .busRdData(busRdData),
        .waveModeLow(waveModeLow), .compareOutputModeA(compareOutputModeA),
        .compareOutputModeB(compareOutputModeB), .captureSourceAnalog(captureSourceAnalog),
        .analogCompOut(analogCompOut), .captureInputPin(captureInputPin),
        .externalCountPin(externalCountPin), .captureFlagClr(captureFlagClr),
        .compareAFlagClr(compareAFlagClr), .overflowFlagClr(overflowFlagClr),
        .captureFlag(captureFlag), .compareAFlag(compareAFlag), .overflowFlag(overflowFlag),
        .waveOutA(waveOutA), .waveOutB(waveOutB));
    pin_side_model i_pins (.clk(clk), .capPin(captureInputPin), .anaOut(analogCompOut),
        .cntPin(externalCountPin));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("mismatches %0d, checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    task automatic check(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        checked++;
        if (got === 16'hxxxx || !(got >= lo && got <= hi) || $isunknown(got)) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        busAddr = a;
        busWrData = d;
        busWrEn = 1'b1;
        @(negedge clk);
        busWrEn = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        busAddr = a;
        busRdEn = 1'b1;
        @(negedge clk);
        busRdEn = 1'b0;
        d = busRdData;
    endtask : rd
    // high byte goes to the shared buffer first, low byte commits
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a + 8'h01, v[15:8]);
        wr(a, v[7:0]);
    endtask : wr16
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a + 8'h01, v[15:8]);
    endtask : rd16
    task automatic clearFlags();
        @(negedge clk);
        captureFlagClr = 1'b1;
        compareAFlagClr = 1'b1;
        overflowFlagClr = 1'b1;
        @(negedge clk);
        captureFlagClr = 1'b0;
        compareAFlagClr = 1'b0;
        overflowFlagClr = 1'b0;
    endtask : clearFlags
    // cycles from the pin edge until the capture flag shows, bounded
    task automatic capLat(input int sel, input logic lvl, output int t);
        i_pins.drive(sel, lvl, 0);
        t = 0;
        while (captureFlag !== 1'b1 && t < 40) begin
            @(negedge clk);
            t++;
        end
    endtask : capLat

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #400us;
        n_mismatch++;
        end_sim();
    end
    initial begin
        logic [15:0] v;
        logic [7:0] b;
        int k, tr, t;
        {rst, busWrEn, busRdEn, captureSourceAnalog} = 4'h8;
        {captureFlagClr, compareAFlagClr, overflowFlagClr} = 3'h0;
        busAddr = 8'h00;
        busWrData = 8'h00;
        waveModeLow = 2'h0;
        compareOutputModeA = COM_TOGGLE;
        compareOutputModeB = COM_TOGGLE;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        // whole window read at reset, unmapped places included
        for (k = 0; k < 10; k++) begin
            rd(8'h80 + k[7:0], b);
            check({8'h00, b}, 16'h0000, 16'h0000);
        end
        wr(ADDR_CTRL_B, 8'hFF);
        rd(ADDR_CTRL_B, b);
        check({8'h00, b}, {8'h00, CTRL_B_MASK}, {8'h00, CTRL_B_MASK});
        wr(ADDR_CTRL_B, REG_RESET);
        wr(ADDR_CTRL_C, 8'hC0);
        rd(ADDR_CTRL_C, b);
        check({8'h00, b}, 16'h0000, 16'h0000);
        wr16(ADDR_CNT_L, 16'h1234);
        repeat (10) @(negedge clk);
        rd16(ADDR_CNT_L, v);
        check(v, 16'h1234, 16'h1234);
        wr16(ADDR_CMPA_L, 16'hABCD);
        rd16(ADDR_CMPA_L, v);
        check(v, 16'hABCD, 16'hABCD);
        // capture with the counter stopped, so the copied value is exact
        wr16(ADDR_CNT_L, 16'h0100);
        wr(ADDR_CTRL_B, 8'h40);
        capLat(0, 1'b1, tr);
        check({15'h0000, captureFlag}, 16'h0001, 16'h0001);
        rd16(ADDR_CAP_L, v);
        check(v, 16'h0100, 16'h0100);
        clearFlags();
        check({15'h0000, captureFlag}, 16'h0000, 16'h0000);
        wr(ADDR_CTRL_B, REG_RESET);
        wr16(ADDR_CNT_L, 16'h0200);
        capLat(0, 1'b0, t);
        rd16(ADDR_CAP_L, v);
        check(v, 16'h0200, 16'h0200);
        clearFlags();
        // filter: a three-sample glitch is swallowed, a real edge costs four cycles
        wr(ADDR_CTRL_B, 8'hC0);
        i_pins.drive(0, 1'b1, 2);
        i_pins.drive(0, 1'b0, 10);
        check({15'h0000, captureFlag}, 16'h0000, 16'h0000);
        capLat(0, 1'b1, t);
        check(16'(t - tr), 16'h0004, 16'h0004);
        i_pins.drive(0, 1'b0, 10);
        clearFlags();
        // comparator as source: the pin is ignored
        wr(ADDR_CTRL_B, 8'h40);
        captureSourceAnalog = 1'b1;
        i_pins.drive(0, 1'b1, 10);
        check({15'h0000, captureFlag}, 16'h0000, 16'h0000);
        capLat(1, 1'b1, t);
        check({15'h0000, captureFlag}, 16'h0001, 16'h0001);
        captureSourceAnalog = 1'b0;
        i_pins.drive(0, 1'b0, 2);
        i_pins.drive(1, 1'b0, 2);
        clearFlags();
        // capture value as top: capture input disconnected
        wr16(ADDR_CAP_L, 16'h8000);
        wr(ADDR_CTRL_B, 8'h58);
        capLat(0, 1'b1, t);
        check({15'h0000, captureFlag}, 16'h0000, 16'h0000);
        rd16(ADDR_CAP_L, v);
        check(v, 16'h8000, 16'h8000);
        i_pins.drive(0, 1'b0, 2);
        // forced match in clear-on-match mode: pins toggle, no flag, no clear
        wr(ADDR_CTRL_B, 8'h08);
        wr16(ADDR_CMPA_L, 16'h0050);
        wr16(ADDR_CNT_L, 16'h0050);
        clearFlags();
        wr(ADDR_CTRL_C, 8'hC0);
        repeat (2) @(negedge clk);
        check({14'h0000, waveOutA, waveOutB}, 16'h0000, 16'h0000);
        check({15'h0000, compareAFlag}, 16'h0000, 16'h0000);
        rd16(ADDR_CNT_L, v);
        check(v, 16'h0050, 16'h0050);
        waveModeLow = 2'h1;
        wr(ADDR_CTRL_C, 8'h80);
        repeat (2) @(negedge clk);
        check({15'h0000, waveOutA}, 16'h0000, 16'h0000);
        waveModeLow = 2'h0;
        // real match while running, then a counter write onto the match value
        wr(ADDR_CTRL_B, REG_RESET);
        wr16(ADDR_CNT_L, 16'h0040);
        wr(ADDR_CTRL_B, 8'h01);
        for (k = 0; k < 40 && compareAFlag !== 1'b1; k++) @(negedge clk);
        check({14'h0000, compareAFlag, waveOutA}, 16'h0003, 16'h0003);
        clearFlags();
        wr16(ADDR_CNT_L, 16'h0050);
        repeat (20) @(negedge clk);
        check({15'h0000, compareAFlag}, 16'h0000, 16'h0000);
        // every internal divisor: twenty ticks each
        for (k = 0; k < 5; k++) begin
            wr(ADDR_CTRL_B, REG_RESET);
            wr16(ADDR_CNT_L, WORD_RESET);
            wr(ADDR_CTRL_B, 8'h01 + k[7:0]);
            repeat (20 * divs[k]) @(negedge clk);
            wr(ADDR_CTRL_B, REG_RESET);
            rd16(ADDR_CNT_L, v);
            check(v, 16'd19, 16'd22);
        end
        // external count pin, rising then falling edges
        for (k = 0; k < 2; k++) begin
            wr16(ADDR_CNT_L, WORD_RESET);
            wr(ADDR_CTRL_B, 8'h07 - k[7:0]);
            i_pins.countPulses(5);
            repeat (5) @(negedge clk);
            wr(ADDR_CTRL_B, REG_RESET);
            rd16(ADDR_CNT_L, v);
            check(v, 16'd5, 16'd5);
        end
        wr16(ADDR_CNT_L, 16'hFFFE);
        wr(ADDR_CTRL_B, 8'h01);
        repeat (3) @(negedge clk);
        check({15'h0000, overflowFlag}, 16'h0001, 16'h0001);
        end_sim();
    end
endmodule : testbench
